/* rtl/usi_pkg.sv */
/*
  Constants for the UPS status indication block: flash timing, charge-level
  pattern timing, register offsets and field positions.
  Assumes a single 100 MHz system clock and a plain register port.
*/
package usi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned SVC_FLASH_HZ   = 2;
  localparam int unsigned SVC_HALF_CYC   = CLK_HZ / (SVC_FLASH_HZ * 2);
  localparam int unsigned DIV_W          = 26;
  // Divider bit periods: bit 23 ~ 84 ms half period (normal flash, ~6 Hz),
  // bit 21 ~ 21 ms half period (fast flash)
  localparam int unsigned NORM_BIT       = 23;
  localparam int unsigned FAST_BIT       = 21;
  // Charge pattern: slot = one normal half period; group = 16 slots
  localparam logic [3:0]  GROUP_SLOTS    = 4'hf;

  // ----------------------------------------------------------------
  // Charge-level bands
  // ----------------------------------------------------------------
  localparam logic [6:0]  LVL_FULL       = 7'h64;
  localparam logic [6:0]  BAND           = 7'h14;

  // ----------------------------------------------------------------
  // Register map (word index = byte address / 4)
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_POLARITY   = 4'h0;
  localparam logic [3:0]  REG_EXTRA      = 4'h1;
  localparam logic [3:0]  REG_REMOTE_CFG = 4'h2;
  localparam logic [3:0]  REG_STATUS     = 4'h3;
  localparam logic [3:0]  REG_LEDS       = 4'h4;

  // Signal output bit positions (polarity and extra conditions)
  localparam int unsigned SO_ALARM       = 0;
  localparam int unsigned SO_BATMODE     = 1;
  localparam int unsigned SO_PGOOD       = 2;
  localparam int unsigned SO_READY       = 3;
  localparam int unsigned SO_OVERPOWER   = 4;
  localparam int unsigned SO_SERVICE     = 5;
  localparam int unsigned SO_N           = 6;

  localparam logic [5:0]  POL_RESET      = 6'h00;
  localparam logic [5:0]  EXTRA_RESET    = 6'h00;
  localparam logic [7:0]  REMOTE_RESET   = 8'h00;

  // LED drive encodings
  typedef enum logic [3:0] {
    LED_OFF   = 4'b0001,
    LED_ON    = 4'b0010,
    LED_FLASH = 4'b0100,
    LED_FAST  = 4'b1000
  } usi_led_mode_t;

endpackage

/* rtl/usi_status.sv */
/*
  UPS status indication: eleven front-panel LEDs, service-mode button,
  six polarity-configurable signal outputs, remote config latch.
  Assumes all inputs are synchronous to clock_i and the button input is
  already debounced.
*/
`timescale 1ns/1ns
`default_nettype none

module usi_status (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Power stage flags
  input  wire logic        input_valid_i,
  input  wire logic        bypass_active_i,
  input  wire logic        bypass_fuse_bad_i,
  input  wire logic        bypass_ok_i,
  input  wire logic        parallel_active_i,
  input  wire logic        parallel_fault_i,
  input  wire logic        output_valid_i,
  input  wire logic        inverter_ok_i,
  input  wire logic        overload_i,
  input  wire logic        protective_bypass_i,
  input  wire logic        rectifier_ok_i,
  input  wire logic        battery_present_i,
  input  wire logic        battery_error_i,
  input  wire logic        battery_feeding_i,
  input  wire logic        battery_charging_i,
  input  wire logic        smart_battery_i,
  input  wire logic [6:0]  charge_level_i,
  input  wire logic        fan_replace_i,
  input  wire logic        battery_replace_i,
  input  wire logic        over_power_i,
  input  wire logic        mains_failed_i,
  // General, battery and parallel alarm causes
  input  wire logic [5:0]  gen_alarm_i,
  input  wire logic [8:0]  bat_alarm_i,
  input  wire logic [2:0]  par_alarm_i,
  // Front panel and remote
  input  wire logic        button_i,
  input  wire logic        remote_i,
  // LEDs, index 1..11 on bits 0..10
  output logic      [10:0] led_o,
  // Signal outputs
  output logic             alarm_o,
  output logic             battery_mode_o,
  output logic             power_good_o,
  output logic             ready_o,
  output logic             overpower_output_o,
  output logic             service_required_o,
  output logic             service_mode_o,
  output logic      [7:0]  remote_cfg_o
);

  // ----------------------------------------------------------------
  // Flash divider and charge pattern
  // ----------------------------------------------------------------
  logic [usi_pkg::DIV_W-1:0] div_r;
  logic [25:0]               svc_cnt_r;
  logic                      svc_ph_r;
  logic                      slot_q_r;
  logic [3:0]                slot_r;
  logic                      norm_ph;
  logic                      fast_ph;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign norm_ph = div_r[usi_pkg::NORM_BIT];
  assign fast_ph = div_r[usi_pkg::FAST_BIT];

  // Exact 2 Hz / 50 % flash for service mode
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      svc_cnt_r <= '0;
      svc_ph_r  <= 1'b0;
    end else if (svc_cnt_r == 26'(usi_pkg::SVC_HALF_CYC - 1)) begin
      svc_cnt_r <= '0;
      svc_ph_r  <= ~svc_ph_r;
    end else begin
      svc_cnt_r <= svc_cnt_r + 1'b1;
    end
  end

  // Pattern slots advance on each normal-flash half period
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      slot_q_r <= 1'b0;
      slot_r   <= '0;
    end else begin
      slot_q_r <= norm_ph;
      if (norm_ph != slot_q_r) begin
        slot_r <= slot_r + 1'b1;
      end
    end
  end

  // Pulses sit on even slots 0,2,..; remaining slots form a long pause
  logic [2:0] pulses;
  logic       charge_ph;

  always_comb begin
    if (charge_level_i > 7'(usi_pkg::BAND * 4)) begin
      pulses = 3'd5;
    end else if (charge_level_i > 7'(usi_pkg::BAND * 3)) begin
      pulses = 3'd4;
    end else if (charge_level_i > 7'(usi_pkg::BAND * 2)) begin
      pulses = 3'd3;
    end else if (charge_level_i > usi_pkg::BAND) begin
      pulses = 3'd2;
    end else begin
      pulses = 3'd1;
    end
    charge_ph = !slot_r[0] && (slot_r[3:1] < pulses);
  end

  // ----------------------------------------------------------------
  // Service mode and remote configuration
  // ----------------------------------------------------------------
  logic       button_q_r;
  logic       service_r;
  logic       remote_q_r;
  logic [7:0] remote_pend_r = usi_pkg::REMOTE_RESET;
  logic [7:0] remote_act_r;
  logic       restart_r;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      button_q_r <= 1'b0;
      service_r  <= 1'b0;
    end else begin
      button_q_r <= button_i;
      if (button_i && !button_q_r) begin
        service_r <= ~service_r;
      end
    end
  end

  // Pending config is applied on remote edge or the first cycle after reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      remote_q_r   <= 1'b0;
      restart_r    <= 1'b1;
      remote_act_r <= usi_pkg::REMOTE_RESET;
    end else begin
      remote_q_r <= remote_i;
      restart_r  <= 1'b0;
      if (restart_r || (remote_i != remote_q_r)) begin
        remote_act_r <= remote_pend_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] pol_r;
  logic [5:0] extra_r;

  // Pending config is not cleared by rst_n_i, so a restart
  // applies what software last wrote
  always_ff @(posedge clock_i) begin
    if (reg_wr_i && reg_addr_i == usi_pkg::REG_REMOTE_CFG) begin
      remote_pend_r <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pol_r   <= usi_pkg::POL_RESET;
      extra_r <= usi_pkg::EXTRA_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == usi_pkg::REG_POLARITY) begin
        pol_r <= reg_wdata_i[5:0];
      end
      if (reg_addr_i == usi_pkg::REG_EXTRA) begin
        extra_r <= reg_wdata_i[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm and signal conditions
  // ----------------------------------------------------------------
  logic              any_alarm;
  logic [usi_pkg::SO_N-1:0] base;
  logic [usi_pkg::SO_N-1:0] sig_nxt;

  always_comb begin
    any_alarm = (|gen_alarm_i) || service_r
              || (|bat_alarm_i)
              || (|par_alarm_i);
    base[usi_pkg::SO_ALARM]     = ~any_alarm;
    base[usi_pkg::SO_BATMODE]   = mains_failed_i && battery_feeding_i;
    base[usi_pkg::SO_PGOOD]     = output_valid_i;
    base[usi_pkg::SO_READY]     = battery_present_i
                                  && charge_level_i == usi_pkg::LVL_FULL;
    base[usi_pkg::SO_OVERPOWER] = over_power_i;
    base[usi_pkg::SO_SERVICE]   = fan_replace_i || battery_replace_i;
  end

  // Extra conditions OR in on the active sense; the alarm output is active low
  genvar gi;
  generate
    for (gi = 0; gi < usi_pkg::SO_N; gi++) begin : g_sig
      if (gi == usi_pkg::SO_ALARM) begin : g_lo
        assign sig_nxt[gi] = (base[gi] && !extra_r[gi]) ^ pol_r[gi];
      end else begin : g_hi
        assign sig_nxt[gi] = (base[gi] || extra_r[gi]) ^ pol_r[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // LED modes
  // ----------------------------------------------------------------
  // Each LED gets one mode; the loop below turns modes into lit bits
  usi_pkg::usi_led_mode_t led_mode [11];
  logic [10:0]            led_nxt;
  logic                   prot;

  always_comb begin
    prot = protective_bypass_i;
    if (input_valid_i) begin
      led_mode[0] = usi_pkg::LED_ON;
    end else begin
      led_mode[0] = usi_pkg::LED_OFF;
    end
    if (bypass_fuse_bad_i) begin
      led_mode[1] = usi_pkg::LED_FLASH;
    end else if (bypass_active_i && bypass_ok_i) begin
      led_mode[1] = usi_pkg::LED_ON;
    end else begin
      led_mode[1] = usi_pkg::LED_OFF;
    end
    if (parallel_fault_i) begin
      led_mode[2] = usi_pkg::LED_FLASH;
    end else if (parallel_active_i) begin
      led_mode[2] = usi_pkg::LED_ON;
    end else begin
      led_mode[2] = usi_pkg::LED_OFF;
    end
    if (remote_act_r != 8'h00) begin
      led_mode[3] = usi_pkg::LED_FLASH;
    end else if (output_valid_i) begin
      led_mode[3] = usi_pkg::LED_ON;
    end else begin
      led_mode[3] = usi_pkg::LED_OFF;
    end
    if (prot) begin
      led_mode[4] = usi_pkg::LED_FAST;
    end else if (overload_i) begin
      led_mode[4] = usi_pkg::LED_FLASH;
    end else if (inverter_ok_i) begin
      led_mode[4] = usi_pkg::LED_ON;
    end else begin
      led_mode[4] = usi_pkg::LED_OFF;
    end
    led_mode[5] = usi_pkg::LED_OFF;
    if (service_r && svc_ph_r) begin
      led_mode[6] = usi_pkg::LED_ON;
    end else if (service_r) begin
      led_mode[6] = usi_pkg::LED_OFF;
    end else if (any_alarm) begin
      led_mode[6] = usi_pkg::LED_ON;
    end else begin
      led_mode[6] = usi_pkg::LED_OFF;
    end
    if (!battery_present_i) begin
      led_mode[7] = usi_pkg::LED_OFF;
    end else if (battery_error_i) begin
      led_mode[7] = usi_pkg::LED_FLASH;
    end else if (charge_level_i == usi_pkg::LVL_FULL) begin
      led_mode[7] = usi_pkg::LED_ON;
    end else if (smart_battery_i && charge_ph) begin
      led_mode[7] = usi_pkg::LED_ON;
    end else if (smart_battery_i) begin
      led_mode[7] = usi_pkg::LED_OFF;
    end else begin
      led_mode[7] = usi_pkg::LED_FLASH;
    end
    if (battery_replace_i) begin
      led_mode[8] = usi_pkg::LED_FLASH;
    end else if (fan_replace_i) begin
      led_mode[8] = usi_pkg::LED_ON;
    end else begin
      led_mode[8] = usi_pkg::LED_OFF;
    end
    if (battery_charging_i) begin
      led_mode[9] = usi_pkg::LED_FLASH;
    end else if (battery_feeding_i) begin
      led_mode[9] = usi_pkg::LED_ON;
    end else begin
      led_mode[9] = usi_pkg::LED_OFF;
    end
    if (prot) begin
      led_mode[10] = usi_pkg::LED_FAST;
    end else if (overload_i) begin
      led_mode[10] = usi_pkg::LED_FLASH;
    end else if (rectifier_ok_i) begin
      led_mode[10] = usi_pkg::LED_ON;
    end else begin
      led_mode[10] = usi_pkg::LED_OFF;
    end
  end

  // Slow and fast flash share the divider, so LEDs 5 and 11 stay in step
  genvar li;
  generate
    for (li = 0; li < 11; li++) begin : g_led
      logic lit;
      always_comb begin
        case (led_mode[li])
          usi_pkg::LED_OFF:   lit = 1'b0;
          usi_pkg::LED_ON:    lit = 1'b1;
          usi_pkg::LED_FLASH: lit = norm_ph;
          usi_pkg::LED_FAST:  lit = fast_ph;
          default:            lit = 1'b0;
        endcase
      end
      assign led_nxt[li] = lit;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output flops and read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      led_o              <= '0;
      alarm_o            <= 1'b1;
      battery_mode_o     <= 1'b0;
      power_good_o       <= 1'b0;
      ready_o            <= 1'b0;
      overpower_output_o <= 1'b0;
      service_required_o <= 1'b0;
      service_mode_o     <= 1'b0;
      remote_cfg_o       <= usi_pkg::REMOTE_RESET;
    end else begin
      led_o              <= led_nxt;
      alarm_o            <= sig_nxt[usi_pkg::SO_ALARM];
      battery_mode_o     <= sig_nxt[usi_pkg::SO_BATMODE];
      power_good_o       <= sig_nxt[usi_pkg::SO_PGOOD];
      ready_o            <= sig_nxt[usi_pkg::SO_READY];
      overpower_output_o <= sig_nxt[usi_pkg::SO_OVERPOWER];
      service_required_o <= sig_nxt[usi_pkg::SO_SERVICE];
      service_mode_o     <= service_r;
      remote_cfg_o       <= remote_act_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        usi_pkg::REG_POLARITY:   reg_rdata_o <= {26'h0, pol_r};
        usi_pkg::REG_EXTRA:      reg_rdata_o <= {26'h0, extra_r};
        usi_pkg::REG_REMOTE_CFG: reg_rdata_o <= {16'h0, remote_act_r, remote_pend_r};
        usi_pkg::REG_STATUS:     reg_rdata_o <= {24'h0, any_alarm, service_r, sig_nxt};
        usi_pkg::REG_LEDS:       reg_rdata_o <= {21'h0, led_o};
        default:                 reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule

`default_nettype wire

/* verif/usi_status_assertions.sv */
/*
  Port-level assertions for the status indication block.
  Assumes a bind from the bench top; mirrors polarity and extra-condition
  writes so that the signal outputs can be predicted.
*/
`timescale 1ns/1ns
`default_nettype none

module usi_status_assertions (
  // Clock, reset and register port
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_rdata_o,
  // Flags
  input  wire logic        input_valid_i,
  input  wire logic        output_valid_i,
  input  wire logic        battery_feeding_i,
  input  wire logic        mains_failed_i,
  input  wire logic        over_power_i,
  input  wire logic        fan_replace_i,
  input  wire logic        battery_replace_i,
  input  wire logic [6:0]  charge_level_i,
  input  wire logic        battery_present_i,
  input  wire logic [5:0]  gen_alarm_i,
  input  wire logic [8:0]  bat_alarm_i,
  input  wire logic [2:0]  par_alarm_i,
  input  wire logic        button_i,
  // Outputs
  input  wire logic [10:0] led_o,
  input  wire logic        alarm_o,
  input  wire logic        battery_mode_o,
  input  wire logic        power_good_o,
  input  wire logic        ready_o,
  input  wire logic        overpower_output_o,
  input  wire logic        service_required_o,
  input  wire logic        service_mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  logic [5:0] pol_q;
  logic [5:0] xtra_q;
  logic       any_c;
  assign any_c = (|gen_alarm_i) || (|bat_alarm_i) || (|par_alarm_i);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i)
      pol_q <= usi_pkg::POL_RESET;
    else if (reg_wr_i && reg_addr_i == usi_pkg::REG_POLARITY)
      pol_q <= reg_wdata_i[5:0];
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i)
      xtra_q <= usi_pkg::EXTRA_RESET;
    else if (reg_wr_i && reg_addr_i == usi_pkg::REG_EXTRA)
      xtra_q <= reg_wdata_i[5:0];
  end

  sequence s_press;
    !button_i ##1 button_i;
  endsequence
  sequence s_toggled;
    service_mode_o != $past(service_mode_o);
  endsequence
  // Active-high output: base or extra condition, then polarity
  property p_sig(o, base, b);
    $past(rst_n_i) |-> o == ($past(base || xtra_q[b]) ^ $past(pol_q[b]));
  endproperty

  a_alarm_level: assert property (
    $past(rst_n_i) && service_mode_o == $past(service_mode_o) |-> alarm_o ==
    (!$past(any_c || service_mode_o || xtra_q[0]) ^ $past(pol_q[0])))
    else $error("alarm output wrong");
  a_batmode_base: assert property (
    $past(rst_n_i) && !$past(pol_q[1] || xtra_q[1]) |->
    ($past(mains_failed_i) || !battery_mode_o) &&
    (!$past(mains_failed_i && battery_feeding_i) || battery_mode_o))
    else $error("battery mode output wrong");
  a_pgood_out: assert property (p_sig(power_good_o, output_valid_i, 2))
    else $error("power good output wrong");
  a_ready_full: assert property (
    p_sig(ready_o, battery_present_i && charge_level_i == usi_pkg::LVL_FULL, 3))
    else $error("ready output wrong");
  a_overpower_out: assert property (p_sig(overpower_output_o, over_power_i, 4))
    else $error("overpower output wrong");
  a_service_req: assert property (
    p_sig(service_required_o, fan_replace_i || battery_replace_i, 5))
    else $error("service required output wrong");
  a_button_toggle: assert property (s_press |-> ##[1:2] s_toggled)
    else $error("button press did not toggle service mode");
  a_input_led: assert property ($past(rst_n_i) |-> led_o[0] == $past(input_valid_i))
    else $error("input indicator wrong");
  a_pol_readback: assert property (
    $past(reg_rd_i && reg_addr_i == usi_pkg::REG_POLARITY) |-> reg_rdata_o[5:0] == $past(pol_q))
    else $error("polarity readback wrong");
endmodule

`default_nettype wire

/* verif/usi_host_model.sv */
/*
  Supervising controller that reads the six signal outputs.
  Assumes the bench hands it the polarity mask that software programmed.
*/
`timescale 1ns/1ns
`default_nettype none

module usi_host_model (
  // Signal outputs of the block, bit order as the polarity register
  input  wire logic [5:0] sig_i,
  // Programmed polarity mask
  input  wire logic [5:0] pol_i,
  // Decoded condition, high = active
  output logic      [5:0] active_o
);
  // Alarm is active low at default polarity, the rest active high
  assign active_o = sig_i ^ pol_i ^ 6'h01;
endmodule

`default_nettype wire

/* verif/usi_status_bench.sv */
/*
  Self-checking bench for the status indication block.
  Assumes the package is compiled first; checker is bound below.
*/
`timescale 1ns/1ns
`default_nettype none

module usi_status_bench;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [21:0] fl = 22'h0;
  logic [6:0]  charge = 7'h00;
  logic [17:0] al = 18'h0;
  logic [5:0]  pol = 6'h00;
  wire  [31:0] rdata;
  wire  [10:0] led;
  wire  [5:0]  sig;
  wire  [5:0]  act;
  wire         svc;
  wire  [7:0]  rcfg;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          lf[6] = '{0, 4, 6, 7, 10, 13};
  int          lb[6] = '{0, 2, 3, 4, 10, 9};
  int          of[4] = '{6, 18, 16, 17};
  int          ob[4] = '{2, 4, 5, 5};

  always #5 clock_i = ~clock_i;

  usi_status dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .input_valid_i(fl[0]), .bypass_active_i(fl[1]), .bypass_fuse_bad_i(fl[2]),
    .bypass_ok_i(fl[3]), .parallel_active_i(fl[4]), .parallel_fault_i(fl[5]),
    .output_valid_i(fl[6]), .inverter_ok_i(fl[7]), .overload_i(fl[8]),
    .protective_bypass_i(fl[9]), .rectifier_ok_i(fl[10]), .battery_present_i(fl[11]),
    .battery_error_i(fl[12]), .battery_feeding_i(fl[13]), .battery_charging_i(fl[14]),
    .smart_battery_i(fl[15]), .charge_level_i(charge), .fan_replace_i(fl[16]),
    .battery_replace_i(fl[17]), .over_power_i(fl[18]), .mains_failed_i(fl[19]),
    .gen_alarm_i(al[5:0]), .bat_alarm_i(al[14:6]), .par_alarm_i(al[17:15]),
    .button_i(fl[20]), .remote_i(fl[21]), .led_o(led), .alarm_o(sig[0]),
    .battery_mode_o(sig[1]), .power_good_o(sig[2]), .ready_o(sig[3]),
    .overpower_output_o(sig[4]), .service_required_o(sig[5]),
    .service_mode_o(svc), .remote_cfg_o(rcfg));

  usi_host_model host_u (.sig_i(sig), .pol_i(pol), .active_o(act));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic drive(input int i, input logic v);
    @(posedge clock_i);
    fl[i] <= v;
    tick(1);
  endtask
  task automatic set_level(input logic [6:0] v);
    @(posedge clock_i);
    charge <= v;
    tick(1);
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic press;
    drive(20, 1'b1);
    drive(20, 1'b0);
    tick(1);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    tick(4);
    chk(led, 11'h0);
    chk(sig, 6'h01);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    reg_read(usi_pkg::REG_POLARITY, 32'h0);
    reg_read(usi_pkg::REG_EXTRA, 32'h0);
    reg_read(4'h7, 32'h0);
    for (int i = 0; i < 18; i++) begin
      @(posedge clock_i);
      al <= 18'h1 << i;
      tick(1);
      chk(sig, 6'h00);
      chk(led[6], 1'b1);
    end
    @(posedge clock_i);
    al <= 18'h0;
    for (int i = 0; i < 6; i++) begin
      pol = 6'h01 << i;
      reg_write(usi_pkg::REG_POLARITY, 32'h1 << i);
      tick(1);
      chk(sig, 6'h01 ^ pol);
      chk(act, 6'h00);
      chk(led[6], 1'b0);
    end
    reg_write(usi_pkg::REG_POLARITY, 32'h3f);
    reg_read(usi_pkg::REG_POLARITY, 32'h3f);
    pol = 6'h00;
    reg_write(usi_pkg::REG_POLARITY, 32'h0);
    for (int i = 0; i < 6; i++) begin
      reg_write(usi_pkg::REG_EXTRA, 32'h1 << i);
      tick(1);
      chk(act, 6'h01 << i);
    end
    reg_write(usi_pkg::REG_EXTRA, 32'h0);
    foreach (of[k]) begin
      drive(of[k], 1'b1);
      chk(act[ob[k]], 1'b1);
      drive(of[k], 1'b0);
      chk(act[ob[k]], 1'b0);
    end
    drive(13, 1'b1);
    drive(19, 1'b1);
    chk(act[1], 1'b1);
    drive(19, 1'b0);
    chk(act[1], 1'b0);
    drive(13, 1'b0);
    foreach (lf[k]) begin
      drive(lf[k], 1'b1);
      chk(led[lb[k]], 1'b1);
      drive(lf[k], 1'b0);
      chk(led[lb[k]], 1'b0);
    end
    drive(3, 1'b1);
    drive(1, 1'b1);
    chk(led[1], 1'b1);
    drive(1, 1'b0);
    drive(3, 1'b0);
    chk(led[1], 1'b0);
    drive(7, 1'b1);
    drive(10, 1'b1);
    drive(9, 1'b1);
    chk(led[4], 1'b0);
    chk(led[10], 1'b0);
    drive(9, 1'b0);
    chk(led[4], 1'b1);
    chk(led[10], 1'b1);
    drive(7, 1'b0);
    drive(10, 1'b0);
    drive(11, 1'b1);
    drive(15, 1'b1);
    set_level(usi_pkg::LVL_FULL);
    chk(led[7], 1'b1);
    chk(act[3], 1'b1);
    set_level(7'h63);
    chk(act[3], 1'b0);
    drive(11, 1'b0);
    drive(15, 1'b0);
    chk(led[7], 1'b0);
    press();
    chk(svc, 1'b1);
    chk(act[0], 1'b1);
    press();
    chk(svc, 1'b0);
    reg_write(usi_pkg::REG_REMOTE_CFG, 32'h5a);
    reg_read(usi_pkg::REG_REMOTE_CFG, 32'h005a);
    chk(rcfg, 8'h00);
    drive(21, 1'b1);
    tick(1);
    chk(rcfg, 8'h5a);
    reg_read(usi_pkg::REG_REMOTE_CFG, 32'h5a5a);
    stop_test();
  end
endmodule

bind usi_status usi_status_assertions chk_u (
  .clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .input_valid_i, .output_valid_i, .battery_feeding_i, .mains_failed_i, .over_power_i,
  .fan_replace_i, .battery_replace_i, .charge_level_i, .battery_present_i, .gen_alarm_i,
  .bat_alarm_i, .par_alarm_i, .button_i, .led_o, .alarm_o, .battery_mode_o, .power_good_o,
  .ready_o,
  .overpower_output_o, .service_required_o, .service_mode_o);

`default_nettype wire
